// ### src/cctu_top.sv
// counter and pulse timer bank with selector-indexed register port
// assumes all inputs synchronous to ref_clk; event inputs are one-cycle pulses
// Operation
// - a counter index register selects which counter later accesses address
// - each counter counts events from a selectable source, including off
// - writing the clear command resets the selected counter's running count
// - live count of the selected counter is readable at read time
// - clear captures the prior count, readable for the selected counter
// - reaching the target count raises done event and drops running flag
// - counter state reads idle, waiting, active, completed or overflowed
// - a selectable gate source starts or enables counter incrementing
// - gate qualifier: rising, falling, any edge, level high, level low
// - a timer index register selects which timer later accesses address
// - timer pulse length programmable in microseconds and raw ticks
// - timer delay after trigger programmable in microseconds and raw ticks
// - elapsed value of selected timer readable in microseconds and ticks
// - timer state reads idle, waiting, active or completed
// - timer start source: off, capture, shutter, line or software bit
// - timer start qualifier: edges or levels; a level enables the timer
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
module cctu_top
    import cctu_pkg::*;
#(
    parameter int NCNT = 2,
    parameter int NTMR = 2,
    parameter int NLINE = 4,
    parameter int NUSR = 2
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [CCTU_DW-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [CCTU_DW-1:0] rd_data,
    input wire logic capture_trigger_signal,
    input wire logic acq_start_signal,
    input wire logic frame_start_signal,
    input wire logic frame_end_signal,
    input wire logic shutter_open_signal,
    input wire logic shutter_open_level,
    input wire logic time_stamp_pulse,
    input wire logic [NLINE-1:0] line_in,
    input wire logic [NUSR-1:0] software_out_bits,
    output logic [NCNT-1:0] count_done_event,
    output logic [NCNT-1:0] count_running_flag,
    output logic [NTMR-1:0] pulse_out,
    output logic irq
);
    localparam int NEV = NCNT + NTMR;
    localparam logic [CCTU_DW-1:0] CNT_MAX = '1;
    localparam logic [CCTU_DW-1:0] TPU = CCTU_DW'(CCTU_TICKS_PER_US);
    // one-hot state: the active code's bit doubles as the running flag flop
    localparam int C_ACT_BIT = $clog2(CCTU_C_ACTIVE);

    typedef struct packed {
        cctu_cnt_t [NCNT-1:0] cnt;
        cctu_tmr_t [NTMR-1:0] tmr;
        logic [3:0] cnt_sel;
        logic [3:0] tmr_sel;
        logic [NLINE-1:0] line_prev;
        logic [NEV-1:0] irq_stat;
        logic [NEV-1:0] irq_mask;
        logic [CCTU_DW-1:0] rd_data;
        logic irq;
    } cctu_state_t;

    cctu_state_t s_reg;
    cctu_state_t s_next;
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    function automatic logic pick(input logic [15:0] v, input logic [3:0] i);
        return v[i];
    endfunction

    function automatic logic qual_hit(input cctu_qual_t q, input logic cur, input logic prev);
        logic r;
        r = 1'b0;
        unique case (q)
            CCTU_Q_RISE: r = cur & ~prev;
            CCTU_Q_FALL: r = ~cur & prev;
            CCTU_Q_ANY: r = cur ^ prev;
            CCTU_Q_HIGH: r = cur;
            CCTU_Q_LOW: r = ~cur;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic is_level(input cctu_qual_t q);
        return (q == CCTU_Q_HIGH) || (q == CCTU_Q_LOW);
    endfunction

    logic [15:0] line16;
    logic [15:0] rise16;
    logic [15:0] cdone16;
    logic [15:0] tdone16;
    logic [15:0] usr16;
    logic [NCNT-1:0] cdone_v;
    logic [NTMR-1:0] tdone_v;

    always_comb
    begin
        for (int i = 0; i < NCNT; i++)
        begin
            cdone_v[i] = s_reg.cnt[i].done;
        end
        for (int j = 0; j < NTMR; j++)
        begin
            tdone_v[j] = s_reg.tmr[j].done;
        end
        line16 = 16'(line_in);
        rise16 = 16'(line_in & ~s_reg.line_prev);
        cdone16 = 16'(cdone_v);
        tdone16 = 16'(tdone_v);
        usr16 = 16'(software_out_bits);
    end

    always_comb
    begin
        logic ev;
        logic gl;
        logic hit;
        logic wsel;
        logic [CCTU_DW:0] endpt;
        logic [CCTU_DW-1:0] el1;
        cctu_cnt_t c;
        cctu_tmr_t t;
        ev = 1'b0;
        gl = 1'b0;
        hit = 1'b0;
        wsel = 1'b0;
        endpt = '0;
        el1 = '0;
        c = s_reg.cnt[0];
        t = s_reg.tmr[0];
        s_next = s_reg;
        s_next.line_prev = line_in;
        s_next.rd_data = '0;

        if (wr_stb && addr == CCTU_CNT_SEL)
        begin
            s_next.cnt_sel = wr_data[3:0];
        end
        if (wr_stb && addr == CCTU_TMR_SEL)
        begin
            s_next.tmr_sel = wr_data[3:0];
        end

        for (int i = 0; i < NCNT; i++)
        begin
            c = s_reg.cnt[i];
            wsel = wr_stb && (s_reg.cnt_sel == 4'(i));
            c.done = 1'b0;
            unique case (c.ev.kind)
                CCTU_EV_CAPT: ev = capture_trigger_signal;
                CCTU_EV_FSTART: ev = frame_start_signal;
                CCTU_EV_FEND: ev = frame_end_signal;
                CCTU_EV_LINE: ev = pick(rise16, c.ev.idx);
                CCTU_EV_CNT: ev = pick(cdone16, c.ev.idx);
                CCTU_EV_TMR: ev = pick(tdone16, c.ev.idx);
                CCTU_EV_TICK: ev = time_stamp_pulse;
                default: ev = 1'b0;
            endcase
            unique case (c.gate.kind)
                CCTU_GT_ACQ: gl = acq_start_signal;
                CCTU_GT_FSTART: gl = frame_start_signal;
                CCTU_GT_FEND: gl = frame_end_signal;
                CCTU_GT_SHUT: gl = shutter_open_signal;
                CCTU_GT_LINE: gl = pick(line16, c.gate.idx);
                CCTU_GT_CNT: gl = pick(cdone16, c.gate.idx);
                CCTU_GT_SHLVL: gl = shutter_open_level;
                default: gl = 1'b0;
            endcase
            hit = qual_hit(c.qual, gl, c.gate_prev);
            c.gate_prev = gl;
            unique case (c.st)
                CCTU_C_IDLE:
                begin
                    if (c.gate.kind != CCTU_GT_OFF)
                    begin
                        c.st = CCTU_C_WAIT;
                    end
                end
                CCTU_C_WAIT:
                begin
                    if (c.gate.kind == CCTU_GT_OFF)
                    begin
                        c.st = CCTU_C_IDLE;
                    end
                    else if (hit)
                    begin
                        c.st = CCTU_C_ACTIVE;
                    end
                end
                CCTU_C_ACTIVE:
                begin
                    // level gating drops back to wait
                    if (is_level(c.qual) && !hit)
                    begin
                        c.st = CCTU_C_WAIT;
                    end
                    else if (ev)
                    begin
                        c.live = c.live + 1'b1;
                        if (c.live == c.target)
                        begin
                            c.st = CCTU_C_DONE;
                            c.done = 1'b1;
                        end
                        else if (c.live == CNT_MAX)
                        begin
                            c.st = CCTU_C_WRAP;
                        end
                    end
                end
                CCTU_C_DONE, CCTU_C_WRAP:
                begin
                    c.st = c.st;
                end
                default: c.st = CCTU_C_IDLE;
            endcase
            if (wsel && addr == CCTU_CNT_SRC)
            begin
                c.ev = {wr_data[CCTU_IDX_LSB+3:CCTU_IDX_LSB],
                    wr_data[CCTU_KIND_LSB+3:CCTU_KIND_LSB]};
            end
            if (wsel && addr == CCTU_CNT_GSRC)
            begin
                c.gate = {wr_data[CCTU_IDX_LSB+3:CCTU_IDX_LSB],
                    wr_data[CCTU_KIND_LSB+3:CCTU_KIND_LSB]};
            end
            if (wsel && addr == CCTU_CNT_GQUAL)
            begin
                c.qual = cctu_qual_t'(wr_data[2:0]);
            end
            if (wsel && addr == CCTU_CNT_TGT)
            begin
                c.target = wr_data;
            end
            if (wsel && addr == CCTU_CNT_CLR)
            begin
                c.capt = s_reg.cnt[i].live;
                c.live = '0;
                c.done = 1'b0;
                c.st = (c.gate.kind == CCTU_GT_OFF) ? CCTU_C_IDLE : CCTU_C_WAIT;
            end
            s_next.cnt[i] = c;
        end

        for (int j = 0; j < NTMR; j++)
        begin
            t = s_reg.tmr[j];
            wsel = wr_stb && (s_reg.tmr_sel == 4'(j));
            t.done = 1'b0;
            unique case (t.start.kind)
                CCTU_TS_CAPT: gl = capture_trigger_signal;
                CCTU_TS_SHUT: gl = shutter_open_signal;
                CCTU_TS_LINE: gl = pick(line16, t.start.idx);
                CCTU_TS_SWOUT: gl = pick(usr16, t.start.idx);
                default: gl = 1'b0;
            endcase
            hit = qual_hit(t.qual, gl, t.start_prev);
            t.start_prev = gl;
            endpt = {1'b0, t.dly} + {1'b0, t.len};
            el1 = t.elapsed + 1'b1;
            unique case (t.st)
                // armed once a start source is chosen
                CCTU_T_IDLE:
                begin
                    if (t.start.kind != CCTU_TS_OFF)
                    begin
                        t.st = CCTU_T_WAIT;
                    end
                end
                CCTU_T_WAIT, CCTU_T_DONE:
                begin
                    if (t.start.kind == CCTU_TS_OFF)
                    begin
                        t.st = CCTU_T_IDLE;
                    end
                    else if (hit)
                    begin
                        t.st = CCTU_T_ACTIVE;
                        t.elapsed = '0;
                        // zero delay starts the pulse at once
                        t.out = (t.dly == '0) && (t.len != '0);
                        if (endpt == '0)
                        begin
                            t.st = CCTU_T_DONE;
                            t.done = 1'b1;
                        end
                    end
                end
                CCTU_T_ACTIVE:
                begin
                    // losing the enable level aborts the run
                    if (is_level(t.qual) && !hit)
                    begin
                        t.st = CCTU_T_WAIT;
                        t.out = 1'b0;
                    end
                    else if ({1'b0, el1} >= endpt)
                    begin
                        t.st = CCTU_T_DONE;
                        t.elapsed = el1;
                        t.out = 1'b0;
                        t.done = 1'b1;
                    end
                    else
                    begin
                        t.elapsed = el1;
                        // pulse once the delay has run out
                        t.out = (el1 >= t.dly);
                    end
                end
                default: t.st = CCTU_T_IDLE;
            endcase
            // pulse length and delay in micro or ticks, then start source and qualifier
            if (wsel && addr == CCTU_TMR_LEN_US)
            begin
                t.len = CCTU_DW'(wr_data * TPU);
            end
            if (wsel && addr == CCTU_TMR_LEN_TK)
            begin
                t.len = wr_data;
            end
            if (wsel && addr == CCTU_TMR_DLY_US)
            begin
                t.dly = CCTU_DW'(wr_data * TPU);
            end
            if (wsel && addr == CCTU_TMR_DLY_TK)
            begin
                t.dly = wr_data;
            end
            if (wsel && addr == CCTU_TMR_SSRC)
            begin
                t.start = {wr_data[CCTU_IDX_LSB+3:CCTU_IDX_LSB],
                    wr_data[CCTU_KIND_LSB+3:CCTU_KIND_LSB]};
            end
            if (wsel && addr == CCTU_TMR_SQUAL)
            begin
                t.qual = cctu_qual_t'(wr_data[2:0]);
            end
            s_next.tmr[j] = t;
        end

        // done events stick; a new event beats a same-cycle clear
        if (wr_stb && addr == CCTU_IRQ_STAT)
        begin
            s_next.irq_stat = s_reg.irq_stat & ~wr_data[NEV-1:0];
        end
        if (wr_stb && addr == CCTU_IRQ_MASK)
        begin
            s_next.irq_mask = wr_data[NEV-1:0];
        end
        for (int i = 0; i < NCNT; i++)
        begin
            s_next.irq_stat[i] = s_next.irq_stat[i] | s_next.cnt[i].done;
        end
        for (int j = 0; j < NTMR; j++)
        begin
            s_next.irq_stat[NCNT+j] = s_next.irq_stat[NCNT+j] | s_next.tmr[j].done;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

        if (rd_stb)
        begin
            c = s_reg.cnt[0];
            t = s_reg.tmr[0];
            for (int i = 0; i < NCNT; i++)
            begin
                if (s_reg.cnt_sel == 4'(i))
                begin
                    c = s_reg.cnt[i];
                end
            end
            for (int j = 0; j < NTMR; j++)
            begin
                if (s_reg.tmr_sel == 4'(j))
                begin
                    t = s_reg.tmr[j];
                end
            end
            // an out-of-range selector reads zero rather than aliasing unit 0
            if (s_reg.cnt_sel >= 4'(NCNT))
            begin
                c = '0;
            end
            if (s_reg.tmr_sel >= 4'(NTMR))
            begin
                t = '0;
            end
            unique case (addr)
                CCTU_CNT_SEL: s_next.rd_data = CCTU_DW'(s_reg.cnt_sel);
                CCTU_CNT_SRC: s_next.rd_data = CCTU_DW'({c.ev.idx, 4'h0, c.ev.kind});
                CCTU_CNT_LIVE: s_next.rd_data = c.live;
                CCTU_CNT_CAPT: s_next.rd_data = c.capt;
                CCTU_CNT_TGT: s_next.rd_data = c.target;
                CCTU_CNT_STATE: s_next.rd_data = CCTU_DW'(c.st);
                CCTU_CNT_GSRC: s_next.rd_data = CCTU_DW'({c.gate.idx, 4'h0, c.gate.kind});
                CCTU_CNT_GQUAL: s_next.rd_data = CCTU_DW'(c.qual);
                CCTU_TMR_SEL: s_next.rd_data = CCTU_DW'(s_reg.tmr_sel);
                CCTU_TMR_LEN_US: s_next.rd_data = t.len / TPU;
                CCTU_TMR_LEN_TK: s_next.rd_data = t.len;
                CCTU_TMR_DLY_US: s_next.rd_data = t.dly / TPU;
                CCTU_TMR_DLY_TK: s_next.rd_data = t.dly;
                CCTU_TMR_EL_US: s_next.rd_data = t.elapsed / TPU;
                CCTU_TMR_EL_TK: s_next.rd_data = t.elapsed;
                CCTU_TMR_STATE: s_next.rd_data = CCTU_DW'(t.st);
                CCTU_TMR_SSRC: s_next.rd_data = CCTU_DW'({t.start.idx, 4'h0, t.start.kind});
                CCTU_TMR_SQUAL: s_next.rd_data = CCTU_DW'(t.qual);
                CCTU_IRQ_STAT: s_next.rd_data = CCTU_DW'(s_reg.irq_stat);
                CCTU_IRQ_MASK: s_next.rd_data = CCTU_DW'(s_reg.irq_mask);
                default: s_next.rd_data = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            s_reg <= '0;
            for (int i = 0; i < NCNT; i++)
            begin
                s_reg.cnt[i].st <= CCTU_C_IDLE;
                s_reg.cnt[i].qual <= CCTU_Q_RISE;
            end
            for (int j = 0; j < NTMR; j++)
            begin
                s_reg.tmr[j].st <= CCTU_T_IDLE;
                s_reg.tmr[j].qual <= CCTU_Q_RISE;
            end
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NCNT; i++)
        begin
            count_done_event[i] = s_reg.cnt[i].done;
            // running flag follows the active state
            count_running_flag[i] = s_reg.cnt[i].st[C_ACT_BIT];
        end
        for (int j = 0; j < NTMR; j++)
        begin
            pulse_out[j] = s_reg.tmr[j].out;
        end
        rd_data = s_reg.rd_data;
        irq = s_reg.irq;
    end
endmodule

// ### src/cctu_pkg.sv
// constants, encodings and carrier types of the counter and timer unit
// assumes one 10 MHz clock and a byte-addressed 32-bit register port
package cctu_pkg;
    localparam int CCTU_DW = 32;
    localparam int CCTU_CLK_HZ = 10000000;
    localparam int CCTU_US_PER_S = 1000000;
    // one raw tick is one clock period
    localparam int CCTU_TICKS_PER_US = CCTU_CLK_HZ / CCTU_US_PER_S;
    // register byte offsets
    localparam logic [7:0] CCTU_CNT_SEL = 8'h00;
    localparam logic [7:0] CCTU_CNT_SRC = 8'h04;
    localparam logic [7:0] CCTU_CNT_CLR = 8'h08;
    localparam logic [7:0] CCTU_CNT_LIVE = 8'h0C;
    localparam logic [7:0] CCTU_CNT_CAPT = 8'h10;
    localparam logic [7:0] CCTU_CNT_TGT = 8'h14;
    localparam logic [7:0] CCTU_CNT_STATE = 8'h18;
    localparam logic [7:0] CCTU_CNT_GSRC = 8'h1C;
    localparam logic [7:0] CCTU_CNT_GQUAL = 8'h20;
    localparam logic [7:0] CCTU_TMR_SEL = 8'h40;
    localparam logic [7:0] CCTU_TMR_LEN_US = 8'h44;
    localparam logic [7:0] CCTU_TMR_LEN_TK = 8'h48;
    localparam logic [7:0] CCTU_TMR_DLY_US = 8'h4C;
    localparam logic [7:0] CCTU_TMR_DLY_TK = 8'h50;
    localparam logic [7:0] CCTU_TMR_EL_US = 8'h54;
    localparam logic [7:0] CCTU_TMR_EL_TK = 8'h58;
    localparam logic [7:0] CCTU_TMR_STATE = 8'h5C;
    localparam logic [7:0] CCTU_TMR_SSRC = 8'h60;
    localparam logic [7:0] CCTU_TMR_SQUAL = 8'h64;
    localparam logic [7:0] CCTU_IRQ_STAT = 8'h70;
    localparam logic [7:0] CCTU_IRQ_MASK = 8'h74;
    // source word: kind in [3:0], unit or line index in [11:8]
    localparam int CCTU_KIND_LSB = 0;
    localparam int CCTU_IDX_LSB = 8;
    // counter input source kinds
    localparam logic [3:0] CCTU_EV_OFF = 4'h0, CCTU_EV_CAPT = 4'h1, CCTU_EV_FSTART = 4'h2,
        CCTU_EV_FEND = 4'h3, CCTU_EV_LINE = 4'h4, CCTU_EV_CNT = 4'h5, CCTU_EV_TMR = 4'h6,
        CCTU_EV_TICK = 4'h7;
    // counter gate source kinds
    localparam logic [3:0] CCTU_GT_OFF = 4'h0, CCTU_GT_ACQ = 4'h1, CCTU_GT_FSTART = 4'h2,
        CCTU_GT_FEND = 4'h3, CCTU_GT_SHUT = 4'h4, CCTU_GT_LINE = 4'h5, CCTU_GT_CNT = 4'h6,
        CCTU_GT_SHLVL = 4'h7;
    // timer start source kinds
    localparam logic [3:0] CCTU_TS_OFF = 4'h0, CCTU_TS_CAPT = 4'h1, CCTU_TS_SHUT = 4'h2,
        CCTU_TS_LINE = 4'h3, CCTU_TS_SWOUT = 4'h4;
    typedef enum logic [2:0] {
        CCTU_Q_RISE = 3'h0, CCTU_Q_FALL = 3'h1, CCTU_Q_ANY = 3'h2,
        CCTU_Q_HIGH = 3'h3, CCTU_Q_LOW = 3'h4
    } cctu_qual_t;
    typedef enum logic [4:0] {
        CCTU_C_IDLE = 5'h01, CCTU_C_WAIT = 5'h02, CCTU_C_ACTIVE = 5'h04,
        CCTU_C_DONE = 5'h08, CCTU_C_WRAP = 5'h10
    } cctu_cst_t;
    typedef enum logic [3:0] {
        CCTU_T_IDLE = 4'h1, CCTU_T_WAIT = 4'h2, CCTU_T_ACTIVE = 4'h4, CCTU_T_DONE = 4'h8
    } cctu_tst_t;
    typedef struct packed {
        logic [3:0] idx;
        logic [3:0] kind;
    } cctu_src_t;
    typedef struct packed {
        logic [CCTU_DW-1:0] live;
        logic [CCTU_DW-1:0] capt;
        logic [CCTU_DW-1:0] target;
        cctu_cst_t st;
        cctu_src_t ev;
        cctu_src_t gate;
        cctu_qual_t qual;
        logic gate_prev;
        logic done;
    } cctu_cnt_t;
    typedef struct packed {
        logic [CCTU_DW-1:0] len;
        logic [CCTU_DW-1:0] dly;
        logic [CCTU_DW-1:0] elapsed;
        cctu_tst_t st;
        cctu_src_t start;
        cctu_qual_t qual;
        logic start_prev;
        logic out;
        logic done;
    } cctu_tmr_t;
endpackage

// ### verif/cctu_top_assertions.sv
// port-level checker for the counter and timer bank
// assumes the register port and outputs of cctu_top; bound below
`timescale 1ns/10ps
module cctu_chk
    import cctu_pkg::*;
#(
    parameter int NCNT = 2,
    parameter int NTMR = 2
)
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [CCTU_DW-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [CCTU_DW-1:0] rd_data,
    input wire logic [NCNT-1:0] count_done_event,
    input wire logic [NCNT-1:0] count_running_flag,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // selector copies: readback is only promised for an in-range unit
    logic [3:0] csel_q;
    logic [3:0] tsel_q;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            csel_q <= '0;
            tsel_q <= '0;
        end
        else
        begin
            csel_q <= (wr_stb && addr == CCTU_CNT_SEL) ? wr_data[3:0] : csel_q;
            tsel_q <= (wr_stb && addr == CCTU_TMR_SEL) ? wr_data[3:0] : tsel_q;
        end
    end
    sequence s_wr_rd(a, lim);
        wr_stb && addr == a && wr_data < lim ##1 rd_stb && addr == a;
    endsequence
    sequence s_done_off;
        count_done_event[0] && !count_running_flag[0] ##1 !count_running_flag[0];
    endsequence
    property p_rd_idle;
        !$past(rd_stb) |-> rd_data == '0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rd_unmapped;
        rd_stb && addr == 8'hFC |=> rd_data == '0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
    property p_sel_rw;
        s_wr_rd(CCTU_CNT_SEL, NCNT) |=> rd_data == $past(wr_data, 2);
    endproperty
    a_sel_rw: assert property (p_sel_rw) else $error("selector readback");
    property p_tgt_rw;
        csel_q < 4'(NCNT) ##0 s_wr_rd(CCTU_CNT_TGT, 32'hFFFFFFFF) |=>
            rd_data == $past(wr_data, 2);
    endproperty
    a_tgt_rw: assert property (p_tgt_rw) else $error("target readback");
    property p_len_rw;
        tsel_q < 4'(NTMR) ##0 s_wr_rd(CCTU_TMR_LEN_TK, 32'hFFFFFFFF) |=>
            rd_data == $past(wr_data, 2);
    endproperty
    a_len_rw: assert property (p_len_rw) else $error("length readback");
    property p_done_pulse;
        |count_done_event |=> (count_done_event & $past(count_done_event)) == '0;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle");
    property p_done_run;
        count_done_event[0] |-> $past(count_running_flag[0]) ##0 s_done_off;
    endproperty
    a_done_run: assert property (p_done_run) else $error("running flag at done");
    // irq can only drop after a status clear or mask write
    property p_irq_fall;
        $fell(irq) |-> $past(wr_stb) || $past(wr_stb, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped unasked");
endmodule

bind cctu_top cctu_chk #(.NCNT(NCNT), .NTMR(NTMR)) u_cctu_chk (.ref_clk(ref_clk), .rstn(rstn),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .count_done_event(count_done_event), .count_running_flag(count_running_flag), .irq(irq));

// ### verif/tb_top.sv
// self-checking bench for the counter and timer bank
// assumes the checker is bound in its own file; bench drives every port
`timescale 1ns/10ps
module tb_top
    import cctu_pkg::*;
;
    logic ref_clk = 0, rstn = 0, wr_stb = 0, rd_stb = 0, capt = 0, acq = 0, fst = 0;
    logic fend = 0, shut = 0, shl = 0, tick = 0;
    logic [7:0] addr = '0;
    logic [31:0] wr_data = '0, rd_data;
    logic [3:0] line_in = '0;
    logic [1:0] sw = '0, done, run, pout;
    logic irq;
    int err_total = 0, n_checks = 0, k;
    always #50 ref_clk = ~ref_clk;
    cctu_top u_cctu_top (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .capture_trigger_signal(capt),
        .acq_start_signal(acq), .frame_start_signal(fst), .frame_end_signal(fend),
        .shutter_open_signal(shut), .shutter_open_level(shl), .time_stamp_pulse(tick),
        .line_in(line_in), .software_out_bits(sw), .count_done_event(done),
        .count_running_flag(run), .pulse_out(pout), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // every bus task starts and ends just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'h1;
        @(posedge ref_clk);
        wr_stb <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge ref_clk);
        rd_stb <= 1'h0;
        @(negedge ref_clk) chk(rd_data, e);
        @(posedge ref_clk);
    endtask
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'h1;
        @(posedge ref_clk);
        wr_stb <= 1'h0;
        rd_stb <= 1'h1;
        @(posedge ref_clk);
        rd_stb <= 1'h0;
        @(negedge ref_clk) chk(rd_data, d);
        @(posedge ref_clk);
    endtask
    // one-cycle pulse on frame start and/or capture trigger
    task automatic pls(input logic f, input logic c);
        fst <= f;
        capt <= c;
        @(posedge ref_clk);
        fst <= 1'h0;
        capt <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        rd(CCTU_CNT_STATE, 32'h1);
        rd(CCTU_TMR_STATE, 32'h1);
        rd(8'hFC, 32'h0);
        wrrd(CCTU_CNT_SEL, 32'h0);
        wrrd(CCTU_CNT_TGT, 32'h3);
        wr(CCTU_CNT_SRC, 32'h1);
        wr(CCTU_CNT_GSRC, 32'h2);
        rd(CCTU_CNT_STATE, 32'h2);
        pls(1'h1, 1'h0);
        @(negedge ref_clk) chk(run[0], 32'h1);
        @(posedge ref_clk);
        pls(1'h0, 1'h1);
        pls(1'h0, 1'h1);
        capt <= 1'h1;
        @(posedge ref_clk);
        capt <= 1'h0;
        @(negedge ref_clk) chk({done[0], run[0]}, 32'h2);
        @(posedge ref_clk);
        rd(CCTU_CNT_STATE, 32'h8);
        rd(CCTU_CNT_LIVE, 32'h3);
        wr(CCTU_IRQ_MASK, 32'h1);
        @(negedge ref_clk) chk(irq, 32'h1);
        @(posedge ref_clk);
        wr(CCTU_IRQ_STAT, 32'h1);
        @(negedge ref_clk) chk(irq, 32'h0);
        @(posedge ref_clk);
        wr(CCTU_CNT_CLR, 32'h0);
        rd(CCTU_CNT_LIVE, 32'h0);
        rd(CCTU_CNT_CAPT, 32'h3);
        rd(CCTU_CNT_STATE, 32'h2);
        wr(CCTU_CNT_GQUAL, 32'h3);
        wr(CCTU_CNT_GSRC, 32'h7);
        shl <= 1'h1;
        @(posedge ref_clk);
        pls(1'h0, 1'h1);
        shl <= 1'h0;
        pls(1'h0, 1'h1);
        rd(CCTU_CNT_LIVE, 32'h1);
        rd(CCTU_CNT_STATE, 32'h2);
        wrrd(CCTU_TMR_SEL, 32'h0);
        wr(CCTU_TMR_DLY_TK, 32'h2);
        wrrd(CCTU_TMR_LEN_TK, 32'h3);
        wr(CCTU_TMR_SSRC, 32'h4);
        rd(CCTU_TMR_STATE, 32'h2);
        sw[0] <= 1'h1;
        k = 0;
        repeat (12) @(negedge ref_clk) k += pout[0];
        chk(k, 32'h3);
        @(posedge ref_clk);
        rd(CCTU_TMR_STATE, 32'h8);
        rd(CCTU_TMR_EL_TK, 32'h5);
        rd(CCTU_TMR_EL_US, 32'h0);
        rd(CCTU_TMR_SSRC, 32'h4);
        rd(CCTU_IRQ_STAT, 32'h4);
        rd(CCTU_TMR_LEN_US, 32'h0);
        rd(CCTU_TMR_DLY_US, 32'h0);
        wr(CCTU_TMR_LEN_US, 32'h1);
        rd(CCTU_TMR_LEN_TK, 32'hA);
        report_and_stop;
    end
endmodule
